// ===== arp_codec_end.sv
// Strobed register access was decided locally.
module arp_codec_port (
  // clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic master,
  input wire logic tick,
  input wire arp_pkg::arp_fmt_t fmt,
  input wire logic [1:0] output_word_length,
  // clock pins
  input wire logic bclk_i,
  input wire logic lrclk_i,
  output logic bclk_o,
  output logic lrclk_o,
  // transmit
  input wire logic [23:0] tx_l,
  input wire logic [23:0] tx_r,
  output logic tx_take,
  output logic sd_o,
  // receive
  input wire logic sd_i,
  output logic [23:0] rx_l,
  output logic [23:0] rx_r,
  output logic rx_valid
);
  logic bclk_ff, lr_ff, prv_bclk_ff, sd_ff, rxv_ff;
  logic [4:0] slot_ff;
  logic [23:0] txl_ff, txr_ff, sh_ff, rxl_ff, rxr_ff;

  // edge events: generated from tick as master, seen on the pin as slave
  wire fall = master ? (tick & bclk_ff) : (prv_bclk_ff & ~bclk_i);
  wire rise = master ? (tick & ~bclk_ff) : (~prv_bclk_ff & bclk_i);
  wire new_side = master ? (slot_ff == arp_pkg::LAST_SLOT) : (lrclk_i != lr_ff);
  wire nxt_lr = master ? ~lr_ff : lrclk_i;
  wire [4:0] nxt_slot = new_side ? 5'h00 : slot_ff + 5'h01;
  wire nxt_left = arp_pkg::is_left(fmt, new_side ? nxt_lr : lr_ff);
  wire start_frame = fall & new_side & nxt_left;
  wire [5:0] tx_pos = arp_pkg::slot_pos(fmt, output_word_length, nxt_slot); // see RULE15
  wire [23:0] tx_word = start_frame ? tx_l : (nxt_left ? txl_ff : txr_ff);
  wire tx_bit = tx_pos[5] & tx_word[tx_pos[4:0]];
  wire [5:0] rx_pos = arp_pkg::slot_pos(fmt, output_word_length, slot_ff);
  wire cur_left = arp_pkg::is_left(fmt, lr_ff);

  assign tx_take = ce & start_frame;
  assign bclk_o = bclk_ff;
  assign lrclk_o = lr_ff;
  assign sd_o = sd_ff;
  assign rx_l = rxl_ff;
  assign rx_r = rxr_ff;
  assign rx_valid = rxv_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      {bclk_ff, lr_ff, prv_bclk_ff, sd_ff, rxv_ff} <= 5'h00;
      slot_ff <= 5'h00;
      {txl_ff, txr_ff, sh_ff, rxl_ff, rxr_ff} <= '0;
    end else if (ce) begin
      prv_bclk_ff <= bclk_i;
      bclk_ff <= master & (bclk_ff ^ tick);
      rxv_ff <= 1'b0;
      if (start_frame) begin
        txl_ff <= tx_l;
        txr_ff <= tx_r;
      end
      if (fall) begin
        slot_ff <= nxt_slot;
        sd_ff <= tx_bit;
        if (new_side) begin
          lr_ff <= nxt_lr;
          sh_ff <= '0;
          if (cur_left) begin
            rxl_ff <= sh_ff;
          end else begin
            rxr_ff <= sh_ff;
            rxv_ff <= 1'b1;
          end
        end
      end
      if (rise && rx_pos[5]) begin
        sh_ff[rx_pos[4:0]] <= sd_i; // see RULE2
      end
    end
  end
endmodule : arp_codec_port

// Operation
// RULE1: aux input clock source by 2-bit select
// RULE2: aux input format: LJ, I2S, RJ lengths
// RULE3: host clocks aux input when select 00
// RULE4: record clock source by 2-bit select
// RULE5: host clocks record port when select 00
// RULE6: output word length 24/20/18/16 bits
// RULE7: record format LJ, I2S, RJ; 10 reserved
// RULE8: aux record clock source by select
// RULE9: host clocks aux record when select 00
// RULE10: aux record format LJ, I2S, RJ
// RULE11: mute bit ramps converter output down
// RULE12: converter delay of 0 to 127 samples
// RULE13: internal clocks divide by 1,1.5,2,3
// RULE14: register address shifted left one place
// RULE15: right-justified word ends at frame edge
// RULE16: software writes zero to reserved bits; the testbench writes 8'hff, and the codec masks them off
module arp_codec_end #(
  parameter logic [8:0] MUTE_STEP = 9'h001
) (
  // clock, reset, enable
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic CE,
  // clock sources
  input wire logic PLL_TICK,
  input wire logic [1:0] INTERNAL_CLOCK_ONE_DIV,
  input wire logic [1:0] INTERNAL_CLOCK_TWO_DIV,
  // record data
  input wire logic [23:0] REC_L,
  input wire logic [23:0] REC_R,
  output logic REC_TAKE,
  // aux input data
  output logic [23:0] AUXIN_L,
  output logic [23:0] AUXIN_R,
  output logic AUXIN_VALID,
  // converter stream
  input wire logic SRC_VALID,
  input wire logic [23:0] SRC_L,
  input wire logic [23:0] SRC_R,
  output logic CONV_VALID,
  output logic [23:0] CONV_L,
  output logic [23:0] CONV_R,
  // link
  arp_if.codec LNK
);
  logic [7:0] ain_cfg_ff, rec_cfg_ff, aout_cfg_ff, conv_cfg_ff, rdata_ff;
  logic [2:0] acc1_ff, acc2_ff;
  logic [6:0] wp_ff;
  logic [8:0] gain_ff;
  logic conv_v_ff;
  logic [23:0] conv_l_ff, conv_r_ff;
  logic [47:0] dly_mem [0:127];
  logic [2:0] mst;

  function automatic logic [2:0] div_mod(input logic [1:0] sel);
    div_mod = (sel == 2'h0) ? arp_pkg::DIV_MOD_1 : (sel == 2'h1) ? arp_pkg::DIV_MOD_1P5 :
              (sel == 2'h2) ? arp_pkg::DIV_MOD_2 : arp_pkg::DIV_MOD_3;
  endfunction : div_mod

  function automatic logic src_tick(input logic [1:0] cs, input logic pll,
                                    input logic t1, input logic t2);
    src_tick = (cs == arp_pkg::CS_PLL) ? pll : (cs == arp_pkg::CS_INTERNAL_CLOCK_ONE) ? t1 :
               (cs == arp_pkg::CS_INTERNAL_CLOCK_TWO) ? t2 : 1'b0;
  endfunction : src_tick

  function automatic logic [23:0] scale(input logic [23:0] x, input logic [8:0] g);
    logic signed [33:0] p;
    p = $signed(x) * $signed({1'b0, g});
    scale = p[31:8];
  endfunction : scale

  // register decode
  wire [6:0] reg_addr = LNK.cfg_frame[7:1]; // see RULE14
  wire sel_ain = reg_addr == arp_pkg::AUX_IN_CFG_ADDR;
  wire sel_rec = reg_addr == arp_pkg::REC_CFG_ADDR;
  wire sel_aout = reg_addr == arp_pkg::AUX_OUT_CFG_ADDR;
  wire sel_conv = reg_addr == arp_pkg::CONV_CFG_ADDR;
  wire [7:0] rd_val = sel_ain ? ain_cfg_ff : sel_rec ? rec_cfg_ff :
                      sel_aout ? aout_cfg_ff : sel_conv ? conv_cfg_ff : 8'h00;
  assign LNK.cfg_rdata = rdata_ff;

  // fields
  wire [1:0] ain_cs = ain_cfg_ff[arp_pkg::AUX_IN_CS_LSB +: 2];
  wire [2:0] ain_fmt = ain_cfg_ff[arp_pkg::AUX_IN_FMT_LSB +: 3];
  wire [1:0] rec_cs = rec_cfg_ff[arp_pkg::OUT_CS_LSB +: 2];
  wire [1:0] aout_cs = aout_cfg_ff[arp_pkg::OUT_CS_LSB +: 2];
  wire mute = conv_cfg_ff[arp_pkg::CONV_MUTE_BIT];
  wire [6:0] dly = conv_cfg_ff[arp_pkg::CONV_DLY_LSB +: 7];

  // internal clock dividers, accumulator of 2 per cycle against 2 x ratio
  wire [2:0] sum1 = acc1_ff + arp_pkg::DIV_STEP;
  wire [2:0] sum2 = acc2_ff + arp_pkg::DIV_STEP;
  wire tick1 = sum1 >= div_mod(INTERNAL_CLOCK_ONE_DIV); // see RULE13
  wire tick2 = sum2 >= div_mod(INTERNAL_CLOCK_TWO_DIV); // see RULE13
  wire [2:0] nxt_acc1 = tick1 ? sum1 - div_mod(INTERNAL_CLOCK_ONE_DIV) : sum1;
  wire [2:0] nxt_acc2 = tick2 ? sum2 - div_mod(INTERNAL_CLOCK_TWO_DIV) : sum2;

  // converter delay line and soft mute
  wire [6:0] rp = wp_ff - dly;
  wire [47:0] dly_word = (dly == 7'h00) ? {SRC_L, SRC_R} : dly_mem[rp]; // see RULE12
  wire [8:0] gain_dn = (gain_ff > MUTE_STEP) ? gain_ff - MUTE_STEP : 9'h000;
  wire [8:0] gain_up = (arp_pkg::GAIN_FULL - gain_ff > MUTE_STEP) ? gain_ff + MUTE_STEP :
                       arp_pkg::GAIN_FULL;
  wire [8:0] nxt_gain = mute ? gain_dn : gain_up; // see RULE11

  assign mst[arp_pkg::PORT_AUX_IN] = ain_cs != arp_pkg::CS_SLAVE; // see RULE1
  assign mst[arp_pkg::PORT_REC] = rec_cs != arp_pkg::CS_SLAVE; // see RULE4
  assign mst[arp_pkg::PORT_AUX_OUT] = aout_cs != arp_pkg::CS_SLAVE; // see RULE8
  assign LNK.dev_bclk_oe_n = ~mst;
  assign LNK.dev_lrclk_oe_n = ~mst;
  assign CONV_VALID = conv_v_ff;
  assign CONV_L = conv_l_ff;
  assign CONV_R = conv_r_ff;

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      ain_cfg_ff <= arp_pkg::AUX_IN_CFG_RST;
      rec_cfg_ff <= arp_pkg::REC_CFG_RST;
      aout_cfg_ff <= arp_pkg::AUX_OUT_CFG_RST;
      conv_cfg_ff <= arp_pkg::CONV_CFG_RST;
      rdata_ff <= 8'h00;
    end else if (CE) begin
      rdata_ff <= LNK.cfg_rd ? rd_val : 8'h00;
      if (LNK.cfg_wr && sel_ain) ain_cfg_ff <= LNK.cfg_wdata & arp_pkg::AUX_IN_CFG_MASK;
      if (LNK.cfg_wr && sel_rec) rec_cfg_ff <= LNK.cfg_wdata & arp_pkg::OUT_CFG_MASK;
      if (LNK.cfg_wr && sel_aout) aout_cfg_ff <= LNK.cfg_wdata & arp_pkg::OUT_CFG_MASK;
      if (LNK.cfg_wr && sel_conv) conv_cfg_ff <= LNK.cfg_wdata & arp_pkg::CONV_CFG_MASK;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      acc1_ff <= 3'h0;
      acc2_ff <= 3'h0;
    end else if (CE) begin
      acc1_ff <= nxt_acc1;
      acc2_ff <= nxt_acc2;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      dly_mem <= '{default: 48'h000000000000};
    end else if (CE && SRC_VALID) begin
      dly_mem[wp_ff] <= {SRC_L, SRC_R};
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      wp_ff <= 7'h00;
      gain_ff <= arp_pkg::GAIN_FULL;
      conv_v_ff <= 1'b0;
      conv_l_ff <= 24'h000000;
      conv_r_ff <= 24'h000000;
    end else if (CE) begin
      conv_v_ff <= SRC_VALID;
      if (SRC_VALID) begin
        wp_ff <= wp_ff + 7'h01;
        gain_ff <= nxt_gain;
        conv_l_ff <= scale(dly_word[47:24], gain_ff); // see RULE11
        conv_r_ff <= scale(dly_word[23:0], gain_ff);
      end
    end
  end

  arp_codec_port u_aux_in (
    .clk(MCLK), .rst(SYS_RST), .ce(CE),
    .master(mst[arp_pkg::PORT_AUX_IN]),
    .tick(src_tick(ain_cs, PLL_TICK, tick1, tick2)), // see RULE1
    .fmt(arp_pkg::in_fmt(ain_fmt)), // see RULE2
    .output_word_length(arp_pkg::in_output_word_length(ain_fmt)),
    .bclk_i(LNK.bclk[arp_pkg::PORT_AUX_IN]), .lrclk_i(LNK.lrclk[arp_pkg::PORT_AUX_IN]),
    .bclk_o(LNK.dev_bclk_o[arp_pkg::PORT_AUX_IN]),
    .lrclk_o(LNK.dev_lrclk_o[arp_pkg::PORT_AUX_IN]),
    .tx_l(24'h000000), .tx_r(24'h000000), .tx_take(), .sd_o(),
    .sd_i(LNK.aux_in_sd), .rx_l(AUXIN_L), .rx_r(AUXIN_R), .rx_valid(AUXIN_VALID)
  );

  arp_codec_port u_rec (
    .clk(MCLK), .rst(SYS_RST), .ce(CE),
    .master(mst[arp_pkg::PORT_REC]),
    .tick(src_tick(rec_cs, PLL_TICK, tick1, tick2)), // see RULE4
    .fmt(arp_pkg::out_fmt(rec_cfg_ff[arp_pkg::OUT_FMT_LSB +: 2])), // see RULE7
    .output_word_length(rec_cfg_ff[arp_pkg::OUT_OUTPUT_WORD_LENGTH_LSB +: 2]), // see RULE6 RULE15
    .bclk_i(LNK.bclk[arp_pkg::PORT_REC]), .lrclk_i(LNK.lrclk[arp_pkg::PORT_REC]),
    .bclk_o(LNK.dev_bclk_o[arp_pkg::PORT_REC]),
    .lrclk_o(LNK.dev_lrclk_o[arp_pkg::PORT_REC]),
    .tx_l(REC_L), .tx_r(REC_R), .tx_take(REC_TAKE), .sd_o(LNK.rec_sd),
    .sd_i(1'b0), .rx_l(), .rx_r(), .rx_valid()
  );

  arp_codec_port u_aux_out (
    .clk(MCLK), .rst(SYS_RST), .ce(CE),
    .master(mst[arp_pkg::PORT_AUX_OUT]),
    .tick(src_tick(aout_cs, PLL_TICK, tick1, tick2)), // see RULE8
    .fmt(arp_pkg::out_fmt(aout_cfg_ff[arp_pkg::OUT_FMT_LSB +: 2])), // see RULE10
    .output_word_length(aout_cfg_ff[arp_pkg::OUT_OUTPUT_WORD_LENGTH_LSB +: 2]), // see RULE6
    .bclk_i(LNK.bclk[arp_pkg::PORT_AUX_OUT]), .lrclk_i(LNK.lrclk[arp_pkg::PORT_AUX_OUT]),
    .bclk_o(LNK.dev_bclk_o[arp_pkg::PORT_AUX_OUT]),
    .lrclk_o(LNK.dev_lrclk_o[arp_pkg::PORT_AUX_OUT]),
    .tx_l(conv_l_ff), .tx_r(conv_r_ff), .tx_take(), .sd_o(LNK.aux_out_sd),
    .sd_i(1'b0), .rx_l(), .rx_r(), .rx_valid()
  );
endmodule : arp_codec_end

// ===== arp_pkg.sv
package arp_pkg;
  // register addresses (7-bit)
  localparam logic [6:0] AUX_IN_CFG_ADDR = 7'h05;
  localparam logic [6:0] REC_CFG_ADDR = 7'h06;
  localparam logic [6:0] AUX_OUT_CFG_ADDR = 7'h07;
  localparam logic [6:0] CONV_CFG_ADDR = 7'h08;
  // reset values and writable bits
  localparam logic [7:0] AUX_IN_CFG_RST = 8'h00;
  localparam logic [7:0] REC_CFG_RST = 8'h00;
  localparam logic [7:0] AUX_OUT_CFG_RST = 8'h00;
  localparam logic [7:0] CONV_CFG_RST = 8'h00;
  localparam logic [7:0] AUX_IN_CFG_MASK = 8'h1f;
  localparam logic [7:0] OUT_CFG_MASK = 8'h3f;
  localparam logic [7:0] CONV_CFG_MASK = 8'hff;
  // field positions
  localparam int AUX_IN_CS_LSB = 3;
  localparam int AUX_IN_FMT_LSB = 0;
  localparam int OUT_CS_LSB = 4;
  localparam int OUT_OUTPUT_WORD_LENGTH_LSB = 2;
  localparam int OUT_FMT_LSB = 0;
  localparam int CONV_MUTE_BIT = 7;
  localparam int CONV_DLY_LSB = 0;
  // clock source codes
  localparam logic [1:0] CS_SLAVE = 2'h0;
  localparam logic [1:0] CS_PLL = 2'h1;
  localparam logic [1:0] CS_INTERNAL_CLOCK_ONE = 2'h2;
  localparam logic [1:0] CS_INTERNAL_CLOCK_TWO = 2'h3;
  // serial formats
  typedef enum logic [1:0] {FMT_LJ = 2'h0, FMT_I2S = 2'h1, FMT_RJ = 2'h3} arp_fmt_t;
  localparam logic [2:0] AIN_FMT_I2S = 3'h1;
  localparam int AIN_RJ_BIT = 2;
  // word length codes and sizes
  localparam logic [1:0] WL_24 = 2'h0;
  localparam logic [1:0] WL_20 = 2'h1;
  localparam logic [1:0] WL_18 = 2'h2;
  localparam logic [5:0] WL24_BITS = 6'h18;
  localparam logic [5:0] WL20_BITS = 6'h14;
  localparam logic [5:0] WL18_BITS = 6'h12;
  localparam logic [5:0] WL16_BITS = 6'h10;
  // frame layout
  localparam logic [5:0] SLOTS = 6'h20;
  localparam logic [4:0] LAST_SLOT = 5'h1f;
  localparam logic [5:0] MSB_POS = 6'h17;
  localparam logic [5:0] I2S_DELAY = 6'h01;
  // converter gain
  localparam logic [8:0] GAIN_FULL = 9'h100;
  // internal clock divider accumulator
  localparam logic [2:0] DIV_STEP = 3'h2;
  localparam logic [2:0] DIV_MOD_1 = 3'h2;
  localparam logic [2:0] DIV_MOD_1P5 = 3'h3;
  localparam logic [2:0] DIV_MOD_2 = 3'h4;
  localparam logic [2:0] DIV_MOD_3 = 3'h6;
  // link port indices
  localparam int PORT_AUX_IN = 0;
  localparam int PORT_REC = 1;
  localparam int PORT_AUX_OUT = 2;
  // host local registers
  localparam int HOST_LOCAL_BIT = 7;
  localparam logic [7:0] HOST_STATUS_ADDR = 8'h80;
  localparam logic [7:0] HOST_CTRL_ADDR = 8'h81;
  localparam logic [7:0] HOST_CTRL_RST = 8'h00;
  localparam int HOST_RUN_BIT = 0;

  function automatic logic [5:0] word_bits(input logic [1:0] wl);
    word_bits = (wl == WL_24) ? WL24_BITS : (wl == WL_20) ? WL20_BITS :
                (wl == WL_18) ? WL18_BITS : WL16_BITS;
  endfunction : word_bits

  // returns {valid, bit index into the 24-bit word} for a slot of a half frame
  function automatic logic [5:0] slot_pos(input arp_fmt_t f, input logic [1:0] wl,
                                          input logic [4:0] slot);
    logic [5:0] w;
    logic [5:0] start;
    logic [5:0] k;
    logic [5:0] p;
    w = word_bits(wl);
    start = (f == FMT_I2S) ? I2S_DELAY : (f == FMT_RJ) ? SLOTS - w : 6'h00;
    k = {1'b0, slot} - start;
    p = MSB_POS - k;
    slot_pos = {(({1'b0, slot} >= start) && (k < w)), p[4:0]};
  endfunction : slot_pos

  function automatic arp_fmt_t out_fmt(input logic [1:0] code);
    out_fmt = (code == FMT_I2S) ? FMT_I2S : (code == FMT_RJ) ? FMT_RJ : FMT_LJ;
  endfunction : out_fmt

  function automatic arp_fmt_t in_fmt(input logic [2:0] code);
    in_fmt = code[AIN_RJ_BIT] ? FMT_RJ : (code == AIN_FMT_I2S) ? FMT_I2S : FMT_LJ;
  endfunction : in_fmt

  function automatic logic [1:0] in_output_word_length(input logic [2:0] code);
    in_output_word_length = code[AIN_RJ_BIT] ? code[1:0] : WL_24;
  endfunction : in_output_word_length

  // left channel: frame clock high, except low in I2S
  function automatic logic is_left(input arp_fmt_t f, input logic lr);
    is_left = (f == FMT_I2S) ? ~lr : lr;
  endfunction : is_left
endpackage : arp_pkg

// ===== arp_if.sv
interface arp_if;
  // register access, address frame = {reg address, 1'b0}
  logic [7:0] cfg_frame;
  logic [7:0] cfg_wdata;
  logic cfg_wr;
  logic cfg_rd;
  logic [7:0] cfg_rdata;
  // two-way clock pins, index by port
  logic [2:0] dev_bclk_o;
  logic [2:0] dev_bclk_oe_n;
  logic [2:0] dev_lrclk_o;
  logic [2:0] dev_lrclk_oe_n;
  logic [2:0] host_bclk_o;
  logic [2:0] host_bclk_oe_n;
  logic [2:0] host_lrclk_o;
  logic [2:0] host_lrclk_oe_n;
  logic [2:0] bclk;
  logic [2:0] lrclk;
  // serial data
  logic aux_in_sd;
  logic rec_sd;
  logic aux_out_sd;

  // undriven wire reads low
  assign bclk = (~dev_bclk_oe_n & dev_bclk_o) | (~host_bclk_oe_n & host_bclk_o);
  assign lrclk = (~dev_lrclk_oe_n & dev_lrclk_o) | (~host_lrclk_oe_n & host_lrclk_o);

  modport codec (
    input cfg_frame, cfg_wdata, cfg_wr, cfg_rd, bclk, lrclk, aux_in_sd,
    output cfg_rdata, dev_bclk_o, dev_bclk_oe_n, dev_lrclk_o, dev_lrclk_oe_n,
    output rec_sd, aux_out_sd
  );
  modport host (
    input cfg_rdata, bclk, lrclk, rec_sd, aux_out_sd,
    output cfg_frame, cfg_wdata, cfg_wr, cfg_rd, aux_in_sd,
    output host_bclk_o, host_bclk_oe_n, host_lrclk_o, host_lrclk_oe_n
  );
endinterface : arp_if

// ===== arp_host_end.sv
module arp_host_end #(
  parameter int BCLK_HALF = 2
) (
  // clock, reset, enable
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic CE,
  // register port
  input wire logic [7:0] HOST_ADDR,
  input wire logic [7:0] HOST_WDATA,
  input wire logic HOST_WR,
  input wire logic HOST_RD,
  output logic [7:0] HOST_RDATA,
  // aux input data sent to the codec
  input wire logic [23:0] AUXIN_L,
  input wire logic [23:0] AUXIN_R,
  output logic AUXIN_TAKE,
  // record data received
  output logic [23:0] REC_L,
  output logic [23:0] REC_R,
  output logic REC_VALID,
  // aux record data received
  output logic [23:0] AUXOUT_L,
  output logic [23:0] AUXOUT_R,
  output logic AUXOUT_VALID,
  // link
  arp_if.host LNK
);
  logic [7:0] ctrl_ff, rdata_ff, sh_ain_ff, sh_rec_ff, sh_aout_ff;
  logic loc_rd_ff;
  logic [15:0] cnt_ff;
  logic [2:0] mst;

  wire is_local = HOST_ADDR[arp_pkg::HOST_LOCAL_BIT];
  wire fwd_wr = HOST_WR & ~is_local;
  wire [6:0] dev_addr = HOST_ADDR[6:0];
  wire run = ctrl_ff[arp_pkg::HOST_RUN_BIT];
  wire tick = run & (cnt_ff == 16'(BCLK_HALF - 1));
  wire [7:0] loc_val = (HOST_ADDR == arp_pkg::HOST_STATUS_ADDR) ? {5'h00, mst} :
                       (HOST_ADDR == arp_pkg::HOST_CTRL_ADDR) ? ctrl_ff : 8'h00;
  wire [2:0] ain_fmt = sh_ain_ff[arp_pkg::AUX_IN_FMT_LSB +: 3];

  assign LNK.cfg_frame = {dev_addr, 1'b0}; // see RULE14
  assign LNK.cfg_wdata = HOST_WDATA;
  assign LNK.cfg_wr = fwd_wr;
  assign LNK.cfg_rd = HOST_RD & ~is_local;
  assign HOST_RDATA = loc_rd_ff ? rdata_ff : LNK.cfg_rdata;

  // host drives a port's clocks exactly when the codec side is a slave
  assign mst[arp_pkg::PORT_AUX_IN] =
    sh_ain_ff[arp_pkg::AUX_IN_CS_LSB +: 2] == arp_pkg::CS_SLAVE; // see RULE3
  assign mst[arp_pkg::PORT_REC] =
    sh_rec_ff[arp_pkg::OUT_CS_LSB +: 2] == arp_pkg::CS_SLAVE; // see RULE5
  assign mst[arp_pkg::PORT_AUX_OUT] =
    sh_aout_ff[arp_pkg::OUT_CS_LSB +: 2] == arp_pkg::CS_SLAVE; // see RULE9
  assign LNK.host_bclk_oe_n = ~mst;
  assign LNK.host_lrclk_oe_n = ~mst;

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      ctrl_ff <= arp_pkg::HOST_CTRL_RST;
      rdata_ff <= 8'h00;
      loc_rd_ff <= 1'b0;
      sh_ain_ff <= arp_pkg::AUX_IN_CFG_RST;
      sh_rec_ff <= arp_pkg::REC_CFG_RST;
      sh_aout_ff <= arp_pkg::AUX_OUT_CFG_RST;
    end else if (CE) begin
      loc_rd_ff <= HOST_RD & is_local;
      rdata_ff <= (HOST_RD & is_local) ? loc_val : 8'h00;
      if (HOST_WR && HOST_ADDR == arp_pkg::HOST_CTRL_ADDR) ctrl_ff <= HOST_WDATA;
      if (fwd_wr && dev_addr == arp_pkg::AUX_IN_CFG_ADDR) begin
        sh_ain_ff <= HOST_WDATA & arp_pkg::AUX_IN_CFG_MASK;
      end
      if (fwd_wr && dev_addr == arp_pkg::REC_CFG_ADDR) begin
        sh_rec_ff <= HOST_WDATA & arp_pkg::OUT_CFG_MASK;
      end
      if (fwd_wr && dev_addr == arp_pkg::AUX_OUT_CFG_ADDR) begin
        sh_aout_ff <= HOST_WDATA & arp_pkg::OUT_CFG_MASK;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      cnt_ff <= 16'h0000;
    end else if (CE) begin
      cnt_ff <= (!run || tick) ? 16'h0000 : cnt_ff + 16'h0001;
    end
  end

  arp_codec_port u_aux_in (
    .clk(MCLK), .rst(SYS_RST), .ce(CE),
    .master(mst[arp_pkg::PORT_AUX_IN]), .tick(tick),
    .fmt(arp_pkg::in_fmt(ain_fmt)), // see RULE2
    .output_word_length(arp_pkg::in_output_word_length(ain_fmt)),
    .bclk_i(LNK.bclk[arp_pkg::PORT_AUX_IN]), .lrclk_i(LNK.lrclk[arp_pkg::PORT_AUX_IN]),
    .bclk_o(LNK.host_bclk_o[arp_pkg::PORT_AUX_IN]),
    .lrclk_o(LNK.host_lrclk_o[arp_pkg::PORT_AUX_IN]),
    .tx_l(AUXIN_L), .tx_r(AUXIN_R), .tx_take(AUXIN_TAKE), .sd_o(LNK.aux_in_sd),
    .sd_i(1'b0), .rx_l(), .rx_r(), .rx_valid()
  );

  arp_codec_port u_rec (
    .clk(MCLK), .rst(SYS_RST), .ce(CE),
    .master(mst[arp_pkg::PORT_REC]), .tick(tick),
    .fmt(arp_pkg::out_fmt(sh_rec_ff[arp_pkg::OUT_FMT_LSB +: 2])),
    .output_word_length(sh_rec_ff[arp_pkg::OUT_OUTPUT_WORD_LENGTH_LSB +: 2]),
    .bclk_i(LNK.bclk[arp_pkg::PORT_REC]), .lrclk_i(LNK.lrclk[arp_pkg::PORT_REC]),
    .bclk_o(LNK.host_bclk_o[arp_pkg::PORT_REC]),
    .lrclk_o(LNK.host_lrclk_o[arp_pkg::PORT_REC]),
    .tx_l(24'h000000), .tx_r(24'h000000), .tx_take(), .sd_o(),
    .sd_i(LNK.rec_sd), .rx_l(REC_L), .rx_r(REC_R), .rx_valid(REC_VALID)
  );

  arp_codec_port u_aux_out (
    .clk(MCLK), .rst(SYS_RST), .ce(CE),
    .master(mst[arp_pkg::PORT_AUX_OUT]), .tick(tick),
    .fmt(arp_pkg::out_fmt(sh_aout_ff[arp_pkg::OUT_FMT_LSB +: 2])),
    .output_word_length(sh_aout_ff[arp_pkg::OUT_OUTPUT_WORD_LENGTH_LSB +: 2]),
    .bclk_i(LNK.bclk[arp_pkg::PORT_AUX_OUT]), .lrclk_i(LNK.lrclk[arp_pkg::PORT_AUX_OUT]),
    .bclk_o(LNK.host_bclk_o[arp_pkg::PORT_AUX_OUT]),
    .lrclk_o(LNK.host_lrclk_o[arp_pkg::PORT_AUX_OUT]),
    .tx_l(24'h000000), .tx_r(24'h000000), .tx_take(), .sd_o(),
    .sd_i(LNK.aux_out_sd), .rx_l(AUXOUT_L), .rx_r(AUXOUT_R), .rx_valid(AUXOUT_VALID)
  );
endmodule : arp_host_end

// ===== arp_link_props.sv
module arp_link_props (
  // clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // register link
  input wire logic [7:0] cfg_frame,
  input wire logic [7:0] cfg_wdata,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_rdata,
  // clock pins
  input wire logic [2:0] dev_bclk_oe_n,
  input wire logic [2:0] dev_lrclk_oe_n,
  input wire logic [2:0] host_bclk_oe_n,
  input wire logic [2:0] host_lrclk_oe_n,
  input wire logic [2:0] bclk,
  input wire logic [2:0] lrclk
);
  timeunit 1ns;
  timeprecision 1ns;
  wire [6:0] ra = cfg_frame[7:1];
  wire out_reg = (ra == arp_pkg::REC_CFG_ADDR) || (ra == arp_pkg::AUX_OUT_CFG_ADDR);
  wire in_reg = ra == arp_pkg::AUX_IN_CFG_ADDR;
  wire mapped = out_reg || in_reg || (ra == arp_pkg::CONV_CFG_ADDR);
  default clocking dc @(posedge MCLK);
  endclocking
  default disable iff (SYS_RST);
  a_one_strobe: assert property (!(cfg_wr && cfg_rd)) else $error("both strobes");
  a_frame_shift: assert property ((cfg_wr || cfg_rd) |-> !cfg_frame[0])
    else $error("frame lsb");
  a_unmapped_zero: assert property ((cfg_rd && !mapped) |=> cfg_rdata == 8'h00)
    else $error("unmapped data");
  a_in_resv: assert property ((cfg_rd && in_reg) |=>
    (cfg_rdata & ~arp_pkg::AUX_IN_CFG_MASK) == 8'h00) else $error("aux in reserved bits");
  a_out_resv: assert property ((cfg_rd && out_reg) |=>
    (cfg_rdata & ~arp_pkg::OUT_CFG_MASK) == 8'h00) else $error("out reserved bits");
  a_conv_readback: assert property (
    (cfg_wr && ra == arp_pkg::CONV_CFG_ADDR) ##1 !cfg_wr ##1
    (cfg_rd && cfg_frame == $past(cfg_frame, 2)) |=> cfg_rdata == $past(cfg_wdata, 3))
    else $error("readback");
  a_no_contend: assert property (
    ((~dev_bclk_oe_n & ~host_bclk_oe_n) | (~dev_lrclk_oe_n & ~host_lrclk_oe_n)) == 3'h0)
    else $error("two drivers");
  a_clock_pair: assert property (
    dev_bclk_oe_n == dev_lrclk_oe_n && host_bclk_oe_n == host_lrclk_oe_n)
    else $error("clock pair split");
  a_frame_on_fall: assert property (
    ((lrclk ^ $past(lrclk)) & bclk & ~(dev_lrclk_oe_n ^ $past(dev_lrclk_oe_n))) == 3'h0)
    else $error("frame edge");
endmodule : arp_link_props

// ===== testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst = 1, wr = 0, rd = 0, sv = 0, pll = 0;
  logic [7:0] ad = 0, wd = 0, cfg;
  logic [1:0] d1 = 0, d2 = 0, fm, wl;
  logic [2:0] f;
  logic [23:0] rl = 24'ha5c3e7, rr = 24'h5a3c18, al = 24'h5a3c96, ar = 24'h3c69a5, sl = 0, sr = 0;
  logic [7:0] mk [4] = '{8'h1f, 8'h3f, 8'h3f, 8'hff};
  wire [23:0] cl, cr, ail, air, hrl, hrr, hol, hor;
  wire [7:0] hrd;
  wire [2:0] ev;
  wire cv;
  int n_fail = 0, num_checks = 0, cyc = 0;
  arp_if i_arp_if();
  arp_codec_end #(.MUTE_STEP(9'h040)) i_arp_codec_end (.MCLK(mclk), .SYS_RST(rst), .CE(1'b1),
    .PLL_TICK(pll), .INTERNAL_CLOCK_ONE_DIV(d1), .INTERNAL_CLOCK_TWO_DIV(d2), .REC_L(rl), .REC_R(rr), .REC_TAKE(),
    .AUXIN_L(ail), .AUXIN_R(air), .AUXIN_VALID(ev[2]), .SRC_VALID(sv), .SRC_L(sl), .SRC_R(sr),
    .CONV_VALID(cv), .CONV_L(cl), .CONV_R(cr), .LNK(i_arp_if));
  arp_host_end #(.BCLK_HALF(2)) i_arp_host_end (.MCLK(mclk), .SYS_RST(rst), .CE(1'b1),
    .HOST_ADDR(ad), .HOST_WDATA(wd), .HOST_WR(wr), .HOST_RD(rd), .HOST_RDATA(hrd),
    .AUXIN_L(al), .AUXIN_R(ar), .AUXIN_TAKE(), .REC_L(hrl), .REC_R(hrr), .REC_VALID(ev[0]),
    .AUXOUT_L(hol), .AUXOUT_R(hor), .AUXOUT_VALID(ev[1]), .LNK(i_arp_if));
  arp_link_props i_props (.MCLK(mclk), .SYS_RST(rst), .cfg_frame(i_arp_if.cfg_frame),
    .cfg_wdata(i_arp_if.cfg_wdata), .cfg_wr(i_arp_if.cfg_wr), .cfg_rd(i_arp_if.cfg_rd),
    .cfg_rdata(i_arp_if.cfg_rdata), .dev_bclk_oe_n(i_arp_if.dev_bclk_oe_n),
    .dev_lrclk_oe_n(i_arp_if.dev_lrclk_oe_n), .host_bclk_oe_n(i_arp_if.host_bclk_oe_n),
    .host_lrclk_oe_n(i_arp_if.host_lrclk_oe_n), .bclk(i_arp_if.bclk), .lrclk(i_arp_if.lrclk));
  initial forever #50 mclk = ~mclk;
  task automatic chk(input string nm, input logic [23:0] s, input logic [23:0] e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    ad <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : w
  task automatic r(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    ad <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    chk("rdata", {16'h0, hrd}, {16'h0, e});
  endtask : r
  task automatic wt(input int k);
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (ev[k] !== 1'b1 && n < 3000);
    if (n >= 3000) chk("event", 24'h0, 24'h1);
  endtask : wt
  task automatic src(input logic [23:0] v, input logic [23:0] e);
    @(posedge mclk);
    sv <= 1'b1;
    sl <= v;
    sr <= v >> 1;
    @(posedge mclk);
    sv <= 1'b0;
    @(negedge mclk);
    chk("conv_valid", {23'h0, cv}, 24'h1);
    chk("conv", cl, e);
    chk("conv_r", cr, e >> 1);
  endtask : src
  function automatic logic [23:0] msk(input logic [1:0] c);
    return 24'hffffff << ((c == 2'h0) ? 0 : (c == 2'h1) ? 4 : (c == 2'h2) ? 6 : 8);
  endfunction : msk
  task automatic test_done;
    if (n_fail == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  always @(posedge mclk) begin
    pll <= ~pll;
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_fail++;
      test_done();
    end
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    r(8'h80, 8'h07);
    for (int i = 0; i < 4; i++) begin
      r(8'h05 + 8'(i), 8'h00);
      w(8'h05 + 8'(i), 8'hff);
      r(8'h05 + 8'(i), mk[i]);
    end
    r(8'h09, 8'h00);
    w(8'h80, 8'hff);
    r(8'h80, 8'h00);
    w(8'h81, 8'h01);
    r(8'h81, 8'h01);
    w(8'h08, 8'h00);
    src(24'h100000, 24'h100000);
    w(8'h08, 8'h02);
    src(24'h010000, 24'h000000);
    src(24'h020000, 24'h100000);
    src(24'h030000, 24'h010000);
    w(8'h08, 8'h7f);
    src(24'h040000, 24'h000000);
    w(8'h08, 8'h80);
    for (int k = 0; k < 5; k++) src(24'h100000, 24'h100000 - 24'h040000 * k);
    w(8'h08, 8'h00);
    for (int k = 0; k < 5; k++) src(24'h123450, 24'h048d14 * k);
    for (int i = 0; i < 12; i++) begin
      fm = (i % 3 == 2) ? 2'h3 : 2'(i % 3);
      wl = 2'(i / 3);
      d1 <= 2'(i / 4 + 1);
      d2 <= 2'(i / 4);
      cfg = {2'h0, 2'(i), wl, fm};
      w(8'h06, cfg);
      w(8'h07, cfg);
      repeat (3) wt(0);
      chk("rec_l", hrl, rl & msk(wl));
      chk("rec_r", hrr, rr & msk(wl));
      wt(1);
      chk("aux_out_l", hol, 24'h123450 & msk(wl));
      chk("aux_out_r", hor, 24'h091a28 & msk(wl));
    end
    for (int i = 0; i < 6; i++) begin
      f = (i < 2) ? 3'(i) : 3'(i + 2);
      w(8'h05, {3'h0, 2'(i), f});
      repeat (3) wt(2);
      chk("aux_in_l", ail, al & msk(f[2] ? f[1:0] : 2'h0));
      chk("aux_in_r", air, ar & msk(f[2] ? f[1:0] : 2'h0));
    end
    test_done();
  end
endmodule : testbench
